// ==== rtl/sdi_pkg.sv ====
// Purpose: Shared constants and types for the serial data/status block
// Assumes: Avalon-MM register access, 32-bit data, word per register
// Notes:   Printed offsets are indexes; byte address is four times index
package sdi_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] SDI_IDX_DATA  = 12'h0f50; // serial_data_byte
  localparam logic [11:0] SDI_IDX_CAUSE = 12'h0f51; // serial_irq_cause
  localparam logic [11:0] SDI_IDX_CTRL  = 12'h0f52; // controller control
  localparam logic [11:0] SDI_IDX_MODE  = 12'h0f53; // mode bits
  localparam logic [11:0] SDI_IDX_ADDR  = 12'h0f54; // own slave address
  localparam logic [11:0] SDI_IDX_STATE = 12'h0f55; // restart cause etc

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SDI_B_TXE   = 7;
  localparam int SDI_B_RXF   = 6;
  localparam int SDI_B_OAM   = 5;
  localparam int SDI_B_BCA   = 4;
  localparam int SDI_B_MRD   = 3;
  localparam int SDI_B_ARB   = 2;
  localparam int SDI_B_SPR   = 1;
  localparam int SDI_B_NAK   = 0;
  localparam int SDI_B_EN    = 7;  // control: controller_enable
  localparam int SDI_B_START = 6;  // control: start request
  localparam int SDI_B_STOP  = 5;  // control: stop request
  localparam int SDI_B_BCE   = 0;  // mode: broadcast_accept_enable
  localparam int SDI_B_A10   = 1;  // mode: 10-bit addressing
  localparam int SDI_B_SLV   = 2;  // mode: slave (else master)

  // ************************************************************
  // Reset values and bus codes
  // ************************************************************
  localparam logic [7:0] SDI_RST_CAUSE = 8'h80;
  localparam logic [7:0] SDI_RST_DATA  = 8'h00;
  localparam logic [7:0] SDI_RST_CTRL  = 8'h00;
  localparam logic [7:0] SDI_GENCALL   = 8'h00;
  localparam logic [7:0] SDI_STARTBYTE = 8'h01;
  localparam logic [4:0] SDI_TENBIT_HDR = 5'b1_1110;

  // Events from the bus engine: one-cycle pulses, plus the rx_data byte value
  typedef struct packed {
    logic       rx_byte;   // data byte finished shifting in
    logic [7:0] rx_data;   // value of that byte
    logic       addr1;     // first address byte done
    logic       addr2;     // second address byte done (10-bit)
    logic       stop_rst;  // stop or repeated start seen
    logic       is_rst;    // that condition was a repeated start
    logic       nack;      // not-acknowledge sent or received
    logic       tx_take;   // engine took holding byte to shifter
  } sdi_evt_t;

  // Status flags
  typedef struct packed {
    logic txe;
    logic rxf;
    logic oam;
    logic bca;
    logic mrd;
    logic arb;
    logic spr;
    logic nak;
  } sdi_flags_t;

endpackage

// ==== rtl/sdi_core.sv ====
// Purpose: Data holding register and interrupt cause flags of a two-wire
//          serial controller, with Avalon-MM register access
// Assumes: Bus engine events are synchronous pulses; SDA pins are pins
// Notes:   Registers answer with waitrequest low one cycle after request
`timescale 1ns/1ps

module sdi_core
  import sdi_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Avalon-MM slave
  input  wire logic [13:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic      [1:0]  o_avs_response,
  // Bus engine events and state
  input  wire sdi_evt_t    i_evt,
  input  wire logic        i_shifting_rx,
  input  wire logic        i_shifting_addr,
  input  wire logic        i_in_slave_xfer,
  input  wire logic        i_start_done,
  input  wire logic        i_stop_done,
  // SDA pin view for arbitration
  input  wire logic        i_sda_pin,
  input  wire logic        i_sda_drive_hi,
  input  wire logic        i_scl_pin,
  // Engine side outputs
  output logic      [7:0]  o_tx_byte,
  output logic             o_tx_valid,
  output logic             o_enable,
  output logic             o_slave_mode,
  output logic             o_start_req,
  output logic             o_stop_req,
  output logic             o_irq_req
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] data;      // holding byte
    sdi_flags_t fl;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [6:0] own;       // own address bits (7-bit: own[6:0])
    logic [1:0] own_hi;    // upper address bits for 10-bit
    logic       rst_cause; // restart_cause_flag
    logic       in_tenbit; // first 10-bit byte matched
    logic       ack;       // answer pending
    logic [31:0] rdata;
    logic [2:0] sda_s;     // two sync stages plus one
    logic [2:0] scl_s;
  } sdi_state_t;

  sdi_state_t s_q;
  sdi_state_t s_d;

  // Word index decode, used by read and write paths
  function automatic logic hit(input logic [13:0] a, input logic [11:0] i);
    hit = (a[13:2] == i) && (a[1:0] == 2'b00);
  endfunction

  logic       req;
  logic       wr_lane0;
  logic       rd_data;
  logic       rd_cause;
  logic       en;
  logic       slv;
  logic       scl_rise;
  logic [7:0] b;
  logic       gc;
  logic       sb;
  logic       own7;

  assign req      = (i_avs_read | i_avs_write) & ~s_q.ack;
  assign wr_lane0 = i_avs_write & req & i_avs_byteenable[0];
  assign rd_data  = i_avs_read & req & hit(i_avs_address, SDI_IDX_DATA);
  assign rd_cause = i_avs_read & req & hit(i_avs_address, SDI_IDX_CAUSE);
  assign en       = s_q.ctrl[SDI_B_EN];
  assign slv      = s_q.mode[SDI_B_SLV];
  assign scl_rise = s_q.scl_s[1] & ~s_q.scl_s[2];
  assign b        = i_evt.rx_data;
  assign gc       = (b == SDI_GENCALL);
  assign sb       = (b == SDI_STARTBYTE);
  assign own7     = (b[7:1] == s_q.own);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ack   = req;
    s_d.sda_s = {s_q.sda_s[1:0], i_sda_pin};
    s_d.scl_s = {s_q.scl_s[1:0], i_scl_pin};

    // Read data captured before any clear this cycle
    // Only a read reloads the data word, so it holds until the next read
    if (req)
    begin
      if (i_avs_read)
      begin
        s_d.rdata = 32'h0000_0000;
        if (hit(i_avs_address, SDI_IDX_DATA))
          s_d.rdata[7:0] = s_q.data;
        else if (hit(i_avs_address, SDI_IDX_CAUSE))
          s_d.rdata[7:0] = s_q.fl;
        else if (hit(i_avs_address, SDI_IDX_CTRL))
          s_d.rdata[7:0] = s_q.ctrl;
        else if (hit(i_avs_address, SDI_IDX_MODE))
          s_d.rdata[7:0] = s_q.mode;
        else if (hit(i_avs_address, SDI_IDX_ADDR))
          s_d.rdata[8:0] = {s_q.own_hi, s_q.own};
        else if (hit(i_avs_address, SDI_IDX_STATE))
          s_d.rdata[0] = s_q.rst_cause;
      end
    end

    // Engine consumed the holding byte: empty again
    if (i_evt.tx_take && en)
      s_d.fl.txe = 1'b1;

    // Software clears (events below win)
    if (rd_data)
      s_d.fl.rxf = 1'b0;
    if (rd_cause)
    begin
      s_d.fl.oam = 1'b0;
      s_d.fl.arb = 1'b0;
      s_d.fl.spr = 1'b0;
      if (slv)
        s_d.fl.nak = 1'b0;
    end

    // Register writes; cause register has no write path
    if (wr_lane0)
    begin
      if (hit(i_avs_address, SDI_IDX_DATA) &&
          !(slv && i_in_slave_xfer && !s_q.fl.mrd))
      begin
        s_d.data   = i_avs_writedata[7:0];
        s_d.fl.txe = 1'b0;
      end
      if (hit(i_avs_address, SDI_IDX_CTRL))
      begin
        s_d.ctrl[SDI_B_EN] = i_avs_writedata[SDI_B_EN];
        // Start and stop can only be set, never written back to 0
        if (i_avs_writedata[SDI_B_START] && en)
        begin
          s_d.ctrl[SDI_B_START] = 1'b1;
          if (!slv)
            s_d.fl.nak = 1'b0;
        end
        if (i_avs_writedata[SDI_B_STOP] && en)
        begin
          s_d.ctrl[SDI_B_STOP] = 1'b1;
          if (!slv)
            s_d.fl.nak = 1'b0;
        end
        s_d.ctrl[4:0] = i_avs_writedata[4:0];
      end
      if (hit(i_avs_address, SDI_IDX_MODE))
        s_d.mode = i_avs_writedata[7:0];
      if (hit(i_avs_address, SDI_IDX_ADDR))
      begin
        s_d.own    = i_avs_writedata[6:0];
        s_d.own_hi = i_avs_writedata[8:7];
      end
    end

    if (i_start_done)
      s_d.ctrl[SDI_B_START] = 1'b0;
    if (i_stop_done)
      s_d.ctrl[SDI_B_STOP] = 1'b0;

    // ************************************************************
    // Bus events set flags only while enabled
    // ************************************************************
    if (en)
    begin
      if (i_evt.rx_byte)
      begin
        s_d.data   = b;
        s_d.fl.rxf = 1'b1;
      end
      if (i_evt.addr1)
      begin
        s_d.fl.mrd = b[0];
        if (slv)
        begin
          s_d.fl.bca = s_q.mode[SDI_B_BCE] && (gc || sb);
          s_d.in_tenbit = 1'b0;
          if (s_q.mode[SDI_B_A10])
            s_d.in_tenbit = (b[7:3] == SDI_TENBIT_HDR) &&
                            (b[2:1] == s_q.own_hi);
          if ((!s_q.mode[SDI_B_A10] && own7) ||
              (s_q.mode[SDI_B_BCE] && gc))
            s_d.fl.oam = 1'b1;
        end
      end
      if (i_evt.addr2 && slv && s_q.in_tenbit &&
          (b[6:0] == s_q.own))
        s_d.fl.oam = 1'b1;
      // Arbitration: drove high, synchronised pin low at SCL rise
      if (!slv && i_sda_drive_hi && scl_rise && !s_q.sda_s[1])
        s_d.fl.arb = 1'b1;
      if (slv && i_evt.stop_rst && i_in_slave_xfer)
      begin
        s_d.fl.spr    = 1'b1;
        s_d.rst_cause = i_evt.is_rst;
      end
      if (i_evt.nack && slv && s_q.fl.mrd)
        s_d.fl.nak = 1'b1;
      if (i_evt.nack && !slv && !s_q.ctrl[SDI_B_START] &&
          !s_q.ctrl[SDI_B_STOP])
        s_d.fl.nak = 1'b1;
    end
    else
    begin
      // Disabled: qualifiers and requests drop
      s_d.fl.bca = 1'b0;
      s_d.fl.mrd = 1'b0;
      s_d.ctrl[SDI_B_START] = 1'b0;
      s_d.ctrl[SDI_B_STOP]  = 1'b0;
      s_d.in_tenbit = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q        <= '0;
      s_q.fl     <= SDI_RST_CAUSE;
      s_q.data   <= SDI_RST_DATA;
      s_q.ctrl   <= SDI_RST_CTRL;
      // Start synchronisers at the idle high level: no false SCL edge
      s_q.sda_s  <= '1;
      s_q.scl_s  <= '1;
    end
    else
      s_q <= s_d;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Empty interrupt hidden while receiving or shifting a read address
  logic txe_irq;
  assign txe_irq = s_q.fl.txe && en && !i_shifting_rx &&
                   !(i_shifting_addr && s_q.fl.mrd);

  // Qualifier bits bca and mrd deliberately left out
  assign o_irq_req = txe_irq | s_q.fl.rxf | s_q.fl.oam |
                     s_q.fl.arb | s_q.fl.spr | s_q.fl.nak;

  // Shifter lives in the engine; only the holding byte is visible
  assign o_tx_byte         = s_q.data;
  assign o_tx_valid        = en && !s_q.fl.txe;
  assign o_enable          = en;
  assign o_slave_mode      = slv;
  assign o_start_req       = s_q.ctrl[SDI_B_START];
  assign o_stop_req        = s_q.ctrl[SDI_B_STOP];
  assign o_avs_readdata    = s_q.rdata;
  assign o_avs_waitrequest = ~s_q.ack;
  assign o_avs_response    = 2'b00;

endmodule

// ==== verif/sdi_sva.sv ====
// Purpose: Port checks for sdi_core
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every sdi_core instance
`timescale 1ns/1ps
module sdi_sva
  import sdi_pkg::*;
(
  // Clock, reset, register bus
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [13:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Engine side
  input wire sdi_evt_t    i_evt,
  input wire logic [7:0]  o_tx_byte,
  input wire logic        o_tx_valid,
  input wire logic        o_enable,
  input wire logic        o_slave_mode,
  input wire logic        o_start_req,
  input wire logic        o_stop_req,
  input wire logic        o_irq_req
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Completed accesses, seen where waitrequest is low
  sequence s_rd_ack;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  sequence s_cause_rd;
    s_rd_ack ##0 i_avs_address[13:2] == SDI_IDX_CAUSE;
  endsequence
  sequence s_data_wr;
    i_avs_write && !o_avs_waitrequest && i_avs_address[13:2] == SDI_IDX_DATA;
  endsequence
  // Two idle cycles: read data must not wander meanwhile
  sequence s_idle2;
    !i_avs_read ##1 !i_avs_read;
  endsequence
  chk_wait_one: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest late");
  chk_irq_cause: assert property (
    s_cause_rd ##0 (o_avs_readdata[7:0] & 8'h67) != 8'h00 |->
      $past(o_irq_req))
    else $error("cause bit set without irq");
  chk_wr_hold: assert property (
    s_data_wr ##0 o_enable && !o_slave_mode |=>
      o_tx_valid && o_tx_byte == $past(i_avs_writedata[7:0]))
    else $error("data write not held");
  chk_rx_irq: assert property (
    i_evt.rx_byte && o_enable |=> o_irq_req)
    else $error("no irq after byte");
  chk_en_off: assert property (
    !o_enable && !$past(o_enable) |-> !o_tx_valid && !o_start_req
      && !o_stop_req)
    else $error("activity while disabled");
  chk_nack_hold: assert property (
    s_cause_rd ##0 o_avs_readdata[0] && !o_slave_mode && !o_start_req
      && !o_stop_req |=> o_irq_req)
    else $error("master nack cleared by read");
  chk_rd_stable: assert property (
    s_idle2 |-> $stable(o_avs_readdata))
    else $error("read data moved");
  chk_hole_zero: assert property (
    s_rd_ack ##0 (i_avs_address[13:2] < SDI_IDX_DATA
      || i_avs_address[13:2] > SDI_IDX_STATE) |-> o_avs_readdata == '0)
    else $error("unmapped read not zero");
endmodule

bind sdi_core sdi_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_evt(i_evt), .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid),
  .o_enable(o_enable), .o_slave_mode(o_slave_mode),
  .o_start_req(o_start_req), .o_stop_req(o_stop_req), .o_irq_req(o_irq_req));

// ==== verif/sdi_bus_peer.sv ====
// Purpose: Other device on the two-wire bus
// Assumes: Open-drain lines with pull-ups
// Notes:   SCL stands high between frames
`timescale 1ns/1ps
module sdi_bus_peer
(
  // From the bench
  input  wire logic i_frame,
  input  wire logic i_pull_sda,
  // Bus lines
  output logic      o_scl,
  output logic      o_sda
);
  // 160 ns clock in frames, odd phase against the system clock
  initial
  begin
    o_scl = 1'h1;
    forever
    begin
      wait (i_frame);
      #81 o_scl = 1'h0;
      #79 o_scl = 1'h1;
    end
  end
  // Released line goes to the pull-up; pulling low wins the bus
  assign o_sda = i_pull_sda ? 1'h0 : 1'h1;
endmodule

// ==== verif/tb_sdi_core.sv ====
// Purpose: Self-checking bench for sdi_core
// Assumes: Bench plays Avalon master and bus engine
// Notes:   Seeded random bytes plus address corner cases
`timescale 1ns/1ps
module tb_sdi_core;
  import sdi_pkg::*;
  logic        i_clk, i_resetn, rd, wr, sd, shrx, sdh, slx, frm, pul;
  logic [13:0] adr;
  logic [31:0] wd, q;
  logic [7:0]  b, e, last;
  sdi_evt_t    ev;
  wire  [31:0] rdata;
  wire  [7:0]  txb;
  wire         scl, sda, wq, irq, txv, en, slv, srq, prq;
  int          fails, comparisons;
  logic [8:0]  tbl [5] = '{9'h100, 9'h101, 9'h154, 9'h155, 9'h000};

  sdi_core u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wq), .o_avs_response(), .i_evt(ev),
    .i_shifting_rx(shrx), .i_shifting_addr(1'h0), .i_in_slave_xfer(slx),
    .i_start_done(sd), .i_stop_done(1'h0), .i_sda_pin(sda),
    .i_sda_drive_hi(sdh), .i_scl_pin(scl), .o_tx_byte(txb),
    .o_tx_valid(txv), .o_enable(en), .o_slave_mode(slv),
    .o_start_req(srq), .o_stop_req(prq), .o_irq_req(irq));
  sdi_bus_peer u_peer (.i_frame(frm), .i_pull_sda(pul), .o_scl(scl),
    .o_sda(sda));

  // ********
  // Helpers
  // ********
  initial
  begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [11:0] i, input logic [8:0] d);
    @(posedge i_clk);
    adr <= {i, 2'h0};
    rd <= !w;
    wr <= w;
    wd <= {23'h00_0000, d};
    @(posedge i_clk);
    while (wq !== 1'h0) @(posedge i_clk);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rc(input string nm, input logic [11:0] i,
                    input logic [7:0] m, x);
    acc(1'h0, i, 9'h000);
    chk(nm, q & {24'h00_0000, m}, {24'h00_0000, x & m});
  endtask
  task automatic pulse(input sdi_evt_t p);
    @(posedge i_clk);
    ev <= p;
    @(posedge i_clk);
    ev <= '0;
  endtask
  // Expected match, broadcast and read bits after one address byte
  function automatic logic [7:0] exp_addr(input logic bce, logic [7:0] a);
    logic gc;
    gc = bce && a[7:1] == 7'h00;
    return {2'h0, a[7:1] == 7'h2a || (gc && !a[0]), gc, a[0], 3'h0};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run takes a few hundred cycles; allow ten thousand
  initial
  begin
    #40000;
    fails++;
    wrap_up();
  end

  // ********
  // Tests
  // ********
  initial
  begin
    void'($urandom(32'h0000_413e));
    {i_resetn, rd, wr, sd, shrx, sdh, slx, frm, pul} = '0;
    adr = '0;
    wd = '0;
    ev = '0;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'h1;
    rc("cause", SDI_IDX_CAUSE, 8'hff, SDI_RST_CAUSE);
    rc("data", SDI_IDX_DATA, 8'hff, 8'h00);
    acc(1'h1, SDI_IDX_CAUSE, 9'h055);
    acc(1'h1, 12'hf57, 9'h0aa);
    rc("cause ro", SDI_IDX_CAUSE, 8'hff, 8'h80);
    rc("hole", 12'hf57, 8'hff, 8'h00);
    $display("test reset done");
    acc(1'h1, SDI_IDX_CTRL, 9'h080);
    chk("irq empty", irq, 1'h1);
    repeat (4)
    begin
      last = $urandom;
      acc(1'h1, SDI_IDX_DATA, {1'h0, last});
      @(negedge i_clk);
      chk("tx byte", txb, last);
      rc("txe clr", SDI_IDX_CAUSE, 8'h80, 8'h00);
      pulse('{tx_take:1'h1, default:0});
      rc("txe set", SDI_IDX_CAUSE, 8'h80, 8'h80);
    end
    shrx <= 1'h1;
    repeat (2) @(negedge i_clk);
    chk("irq masked", irq, 1'h0);
    @(posedge i_clk);
    shrx <= 1'h0;
    repeat (4)
    begin
      b = $urandom;
      pulse('{rx_byte:1'h1, rx_data:b, default:0});
      rc("rxf", SDI_IDX_CAUSE, 8'h40, 8'h40);
      rc("rx data", SDI_IDX_DATA, 8'hff, b);
      rc("rxf clr", SDI_IDX_CAUSE, 8'h40, 8'h00);
    end
    $display("test data done");
    pulse('{nack:1'h1, default:0});
    rc("nak", SDI_IDX_CAUSE, 8'h01, 8'h01);
    rc("nak kept", SDI_IDX_CAUSE, 8'h01, 8'h01);
    acc(1'h1, SDI_IDX_CTRL, 9'h0c0);
    rc("nak start", SDI_IDX_CAUSE, 8'h01, 8'h00);
    pulse('{nack:1'h1, default:0});
    rc("nak gated", SDI_IDX_CAUSE, 8'h01, 8'h00);
    @(posedge i_clk);
    sd <= 1'h1;
    @(posedge i_clk);
    sd <= 1'h0;
    sdh <= 1'h1;
    pul <= 1'h1;
    frm <= 1'h1;
    repeat (100) @(posedge i_clk);
    {frm, pul, sdh} <= 3'h0;
    rc("arb", SDI_IDX_CAUSE, 8'h04, 8'h04);
    rc("arb clr", SDI_IDX_CAUSE, 8'h04, 8'h00);
    $display("test master done");
    acc(1'h1, SDI_IDX_ADDR, 9'h02a);
    foreach (tbl[i])
    begin
      acc(1'h1, SDI_IDX_MODE, {8'h02, tbl[i][8]});
      pulse('{addr1:1'h1, rx_data:tbl[i][7:0], default:0});
      e = exp_addr(tbl[i][8], tbl[i][7:0]);
      rc("addr", SDI_IDX_CAUSE, e[5] ? 8'h38 : 8'h30, e);
      rc("oam clr", SDI_IDX_CAUSE, 8'h20, 8'h00);
    end
    acc(1'h1, SDI_IDX_MODE, 9'h004);
    pulse('{addr1:1'h1, rx_data:8'h54, default:0});
    slx <= 1'h1;
    acc(1'h1, SDI_IDX_DATA, 9'h05a);
    @(negedge i_clk);
    chk("blocked", txb, b);
    pulse('{stop_rst:1'h1, default:0});
    slx <= 1'h0;
    rc("spr", SDI_IDX_CAUSE, 8'h02, 8'h02);
    rc("spr clr", SDI_IDX_CAUSE, 8'h02, 8'h00);
    pulse('{addr1:1'h1, rx_data:8'h55, default:0});
    pulse('{nack:1'h1, default:0});
    rc("s nak", SDI_IDX_CAUSE, 8'h09, 8'h09);
    rc("s nak clr", SDI_IDX_CAUSE, 8'h01, 8'h00);
    pulse('{stop_rst:1'h1, default:0});
    acc(1'h1, SDI_IDX_ADDR, 9'h12a);
    acc(1'h1, SDI_IDX_MODE, 9'h006);
    pulse('{addr1:1'h1, rx_data:8'hf6, default:0});
    pulse('{addr2:1'h1, rx_data:8'h2a, default:0});
    rc("ten wrong", SDI_IDX_CAUSE, 8'h20, 8'h00);
    pulse('{addr1:1'h1, rx_data:8'hf4, default:0});
    rc("ten first", SDI_IDX_CAUSE, 8'h20, 8'h00);
    pulse('{addr2:1'h1, rx_data:8'h2a, default:0});
    rc("ten both", SDI_IDX_CAUSE, 8'h20, 8'h20);
    $display("test slave done");
    acc(1'h1, SDI_IDX_CTRL, 9'h000);
    rc("off", SDI_IDX_CAUSE, 8'h18, 8'h00);
    $display("test disable done");
    wrap_up();
  end
endmodule
